// file: src/ccd_pkg.sv
// Package: opcodes, fields, register map and types for the clear/complement/decrement executor
package ccd_pkg;
	localparam int unsigned INSN_W   = 14;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned FADDR_W  = 7;
	localparam int unsigned DEST_BIT = 7;
	localparam int unsigned OP_HI    = 13;
	localparam int unsigned OP_LO    = 8;
	localparam int unsigned FILE_DEPTH = 128;

	localparam logic [5:0] OP6_INVERT  = 6'h09;
	localparam logic [5:0] OP6_DECR    = 6'h03;
	localparam logic [5:0] OP6_CLRGRP  = 6'h01;
	localparam logic [INSN_W-1:0] OP_CLEAR_WORK = 14'h0103;
	localparam logic [INSN_W-1:0] OP_DOG_CLEAR  = 14'h0064;

	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE  = 8'h01;

	// Register map (byte addresses)
	localparam logic [7:0] ADDR_INSN   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_WORK   = 8'h08;
	localparam logic [7:0] ADDR_FILE   = 8'h0c;
	localparam logic [7:0] ADDR_DOGCNT = 8'h10;
	localparam logic [7:0] ADDR_FSEL   = 8'h14;

	localparam int unsigned ST_ZERO = 0;
	localparam int unsigned ST_PDOWN = 1;
	localparam int unsigned ST_TOUT  = 2;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	typedef enum logic [4:0] {
		OPK_NONE  = 5'h00,
		OPK_ZERO_FILE = 5'h01,
		OPK_ZERO_WORK = 5'h02,
		OPK_INV   = 5'h04,
		OPK_DOG_CLEAR = 5'h08,
		OPK_DEC   = 5'h10
	} op_kind_e;

	typedef struct packed {
		op_kind_e                 kind;
		logic                     dest_file;
		logic [FADDR_W-1:0]       faddr;
	} decoded_s;

	typedef struct packed {
		logic                     sel;
		logic                     write;
		logic [7:0]               addr;
	} bus_req_s;
endpackage : ccd_pkg

// file: src/ccd_exec.sv
// Executor for clear, complement, watchdog-clear and decrement instructions behind an AHB-Lite slave
`timescale 1ns/10ps
`default_nettype none
module ccd_exec
	import ccd_pkg::*;
#(
	parameter int unsigned DEPTH = FILE_DEPTH
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             watchdog_clear_op,
	output logic             time_out_flag,
	output logic             power_down_flag
);
	function automatic decoded_s decode(input logic [INSN_W-1:0] w);
		decoded_s d;
		d.kind      = OPK_NONE;
		d.dest_file = w[DEST_BIT];
		d.faddr     = w[FADDR_W-1:0];
		if (w == OP_CLEAR_WORK) begin
			d.kind = OPK_ZERO_WORK;
		end else if (w == OP_DOG_CLEAR) begin
			d.kind = OPK_DOG_CLEAR;
		end else if (w[OP_HI:OP_LO] == OP6_CLRGRP && w[DEST_BIT]) begin
			d.kind = OPK_ZERO_FILE;
		end else if (w[OP_HI:OP_LO] == OP6_INVERT) begin
			d.kind = OPK_INV;
		end else if (w[OP_HI:OP_LO] == OP6_DECR) begin
			d.kind = OPK_DEC;
		end
		return d;
	endfunction : decode

	logic [DATA_W-1:0]  file_mem [DEPTH];
	logic [DATA_W-1:0]  work_r,   work_nxt;
	logic               zero_r,   zero_nxt;
	logic               to_r,     to_nxt;
	logic               pdown_r,  pdown_nxt;
	logic [7:0]         dogcnt_r, dogcnt_nxt;
	logic [7:0]         presc_r,  presc_nxt;
	logic [FADDR_W-1:0] fsel_r,   fsel_nxt;
	logic               wdtop_r,  wdtop_nxt;
	bus_req_s           req_r,    req_nxt;
	logic [31:0]        rdata_r,  rdata_nxt;
	logic               fwr_en;
	logic [FADDR_W-1:0] fwr_addr;
	logic [DATA_W-1:0]  fwr_data;
	logic               insn_go;
	decoded_s           dec;
	logic [DATA_W-1:0]  src;
	logic [DATA_W-1:0]  res;

	// Address phase captured; data phase acts, so the slave has zero wait states
	always_comb begin
		req_nxt = req_r;
		if (hready) begin
			req_nxt.sel   = hsel && htrans[1];
			req_nxt.write = hwrite;
			req_nxt.addr  = haddr[7:0];
		end
	end

	assign insn_go = req_r.sel && req_r.write && req_r.addr == ADDR_INSN;
	assign dec     = decode(hwdata[INSN_W-1:0]);
	assign src     = file_mem[dec.faddr];

	// One instruction per bus write completes in that single cycle
	always_comb begin
		work_nxt  = work_r;
		zero_nxt  = zero_r;
		to_nxt    = to_r;
		pdown_nxt = pdown_r;
		wdtop_nxt = 1'b0;
		presc_nxt = presc_r + ONE_BYTE;
		// Counter steps when the prescaler wraps
		dogcnt_nxt = (&presc_r) ? dogcnt_r + ONE_BYTE : dogcnt_r;
		fsel_nxt  = fsel_r;
		fwr_en    = 1'b0;
		fwr_addr  = dec.faddr;
		fwr_data  = ZERO_BYTE;
		res       = ZERO_BYTE;
		if (req_r.sel && req_r.write && req_r.addr == ADDR_FSEL) begin
			fsel_nxt = hwdata[FADDR_W-1:0];
		end
		if (req_r.sel && req_r.write && req_r.addr == ADDR_FILE) begin
			fwr_en   = 1'b1;
			fwr_addr = fsel_r;
			fwr_data = hwdata[DATA_W-1:0];
		end
		if (req_r.sel && req_r.write && req_r.addr == ADDR_WORK) begin
			work_nxt = hwdata[DATA_W-1:0];
		end
		if (insn_go) begin
			case (dec.kind)
				OPK_ZERO_FILE: begin
					fwr_en   = 1'b1;
					fwr_data = ZERO_BYTE;
					zero_nxt = 1'b1;
				end
				OPK_ZERO_WORK: begin
					work_nxt = ZERO_BYTE;
					zero_nxt = 1'b1;
				end
				OPK_INV, OPK_DEC: begin
					res      = (dec.kind == OPK_INV) ? ~src : src - ONE_BYTE;
					zero_nxt = (res == ZERO_BYTE);
					if (dec.dest_file) begin
						fwr_en   = 1'b1;
						fwr_data = res;
					end else begin
						work_nxt = res;
					end
				end
				OPK_DOG_CLEAR: begin
					dogcnt_nxt = ZERO_BYTE;
					presc_nxt = ZERO_BYTE;
					to_nxt    = 1'b1;
					pdown_nxt = 1'b1;
					wdtop_nxt = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				ADDR_STATUS: rdata_nxt = {29'h0, to_nxt, pdown_nxt, zero_nxt};
				ADDR_WORK:   rdata_nxt = {24'h0, work_nxt};
				// Bypass so a read right behind a file write sees the new byte
				ADDR_FILE:   rdata_nxt = {24'h0, (fwr_en && fwr_addr == fsel_nxt) ? fwr_data : file_mem[fsel_nxt]};
				ADDR_DOGCNT: rdata_nxt = {24'h0, dogcnt_nxt};
				ADDR_FSEL:   rdata_nxt = {25'h0, fsel_nxt};
				default:     rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_r   <= '0;
			work_r  <= ZERO_BYTE;
			zero_r  <= 1'b0;
			to_r    <= 1'b1;
			pdown_r <= 1'b1;
			dogcnt_r <= ZERO_BYTE;
			presc_r <= ZERO_BYTE;
			fsel_r  <= '0;
			wdtop_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			req_r   <= req_nxt;
			work_r  <= work_nxt;
			zero_r  <= zero_nxt;
			to_r    <= to_nxt;
			pdown_r <= pdown_nxt;
			dogcnt_r <= dogcnt_nxt;
			presc_r <= presc_nxt;
			fsel_r  <= fsel_nxt;
			wdtop_r <= wdtop_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// File array has no reset, like the real data memory
	always_ff @(posedge hclk) begin
		if (fwr_en) begin
			file_mem[fwr_addr] <= fwr_data;
		end
	end

	// Read data is registered in the address phase; it sees this cycle's write effects
	assign hrdata            = rdata_r;
	assign hreadyout         = 1'b1;
	assign hresp             = 1'b0;
	assign watchdog_clear_op = wdtop_r;
	assign time_out_flag     = to_r;
	assign power_down_flag   = pdown_r;
endmodule : ccd_exec
`default_nettype wire

// file: dv/ccd_exec_monitor.sv
// Checker for the executor's bus answer and watchdog outputs
`timescale 1ns/10ps
`default_nettype none
module ccd_exec_monitor
	import ccd_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        watchdog_clear_op,
	input wire logic        time_out_flag,
	input wire logic        power_down_flag
);
	logic       dw_r;
	logic       dr_r;
	logic [7:0] da_r;
	logic       dogclr_c;
	// Data phase tracking, since hwdata only means something one cycle after the address
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dw_r <= 1'b0;
			dr_r <= 1'b0;
			da_r <= 8'h00;
		end else begin
			dw_r <= hsel && htrans[1] && hready && hwrite;
			dr_r <= hsel && htrans[1] && hready && !hwrite;
			da_r <= haddr[7:0];
		end
	end
	assign dogclr_c = dw_r && da_r == ADDR_INSN && hwdata[13:0] == OP_DOG_CLEAR;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_high: assert property (hreadyout) else $error("wait state seen");
	a_resp_okay: assert property (!hresp) else $error("error response seen");
	a_dog_pulse: assert property (dogclr_c |=> watchdog_clear_op) else $error("no clear pulse");
	a_pulse_cause: assert property (watchdog_clear_op |-> $past(dogclr_c)) else $error("stray pulse");
	a_flags_set: assert property (watchdog_clear_op |-> time_out_flag && power_down_flag)
		else $error("flags not set");
	a_flags_hold: assert property (!$fell(time_out_flag) && !$fell(power_down_flag)) else $error("flag fell");
	a_fsel_width: assert property (dr_r && da_r == ADDR_FSEL |-> hrdata[31:7] == 25'h0)
		else $error("address wider than 7 bits");
	a_status_flags: assert property (dr_r && da_r == ADDR_STATUS |-> hrdata[2:1] == {time_out_flag, power_down_flag})
		else $error("status flags differ");
endmodule : ccd_exec_monitor
bind ccd_exec ccd_exec_monitor mon_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
	.hreadyout, .hresp, .watchdog_clear_op, .time_out_flag, .power_down_flag);
`default_nettype wire

// file: dv/ccd_fetch_model.sv
// Instruction fetch and file side, reaching the executor as a bus master
`timescale 1ns/10ps
`default_nettype none
module ccd_fetch_model (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : xf
endmodule : ccd_fetch_model
`default_nettype wire

// file: dv/ccd_exec_tb.sv
// Self-checking bench for the clear, complement and decrement executor
`timescale 1ns/10ps
`default_nettype none
module ccd_exec_tb
	import ccd_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, d, z;
	logic [31:0] haddr, hwdata, hrdata, q, rn;
	logic [1:0] htrans, k;
	logic [2:0] hsize;
	logic [7:0] v, w, r, ef, ew;
	logic [6:0] f;
	int miscompares, n_tests;
	ccd_exec dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .watchdog_clear_op(), .time_out_flag(), .power_down_flag());
	ccd_fetch_model fm_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	function automatic logic [13:0] ins(input logic [1:0] k, input logic d, input logic [6:0] f);
		case (k)
			2'h0: return 14'h0180 | {7'h0, f};
			2'h1: return OP_CLEAR_WORK;
			2'h2: return {OP6_INVERT, d, f};
			default: return {OP6_DECR, d, f};
		endcase
	endfunction : ins
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		miscompares++;
		end_of_test();
	end
	initial begin
		hresetn = 1'b0;
		void'($urandom(68));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		fm_u.xf(1'b0, ADDR_STATUS, 32'h0, q);
		chk(q, 32'h6);
		for (int i = 0; i < 40; i++) begin
			rn = $urandom;
			k = rn[1:0];
			d = rn[2];
			// Both ends of the address range and of the data range come first
			f = (i < 2) ? {7{i[0]}} : rn[9:3];
			v = (i < 8) ? {8{i[0]}} : rn[17:10];
			w = rn[25:18];
			r = (k == 2'h2) ? ~v : (k == 2'h3) ? v - 8'h01 : 8'h00;
			ef = (k == 2'h0) ? 8'h00 : (k[1] && d) ? r : v;
			ew = (k == 2'h1) ? 8'h00 : (k[1] && !d) ? r : w;
			fm_u.xf(1'b1, ADDR_FSEL, {25'h0, f}, q);
			fm_u.xf(1'b1, ADDR_FILE, {24'h0, v}, q);
			fm_u.xf(1'b1, ADDR_WORK, {24'h0, w}, q);
			fm_u.xf(1'b1, ADDR_INSN, {18'h0, ins(k, d, f)}, q);
			fm_u.xf(1'b0, ADDR_WORK, 32'h0, q);
			chk(q, {24'h0, ew});
			fm_u.xf(1'b0, ADDR_FILE, 32'h0, q);
			chk(q, {24'h0, ef});
			fm_u.xf(1'b0, ADDR_STATUS, 32'h0, q);
			chk(q, {29'h0, 2'h3, r == 8'h00});
			$display("test %0d done", i);
		end
		fm_u.xf(1'b1, ADDR_INSN, {18'h0, OP_DOG_CLEAR}, q);
		fm_u.xf(1'b0, ADDR_DOGCNT, 32'h0, q);
		chk(q, 32'h0);
		$display("watchdog test done");
		end_of_test();
	end
endmodule : ccd_exec_tb
`default_nettype wire
